// file: core/irq_prio_consts.vh
`ifndef IRQ_PRIO_CONSTS_VH
`define IRQ_PRIO_CONSTS_VH
// ==========================================================
// Register byte addresses on the bus
`define IDX_PRIO_PORT_T16 16'hFF20
`define IDX_PRIO_T8_SER_CLK_LCD 16'hFF21
`define IDX_PRIO_ADC_TOUCH 16'hFF22
`define IDX_EN_PORT 16'hFF23
`define IDX_EN_TIMER_SERIAL 16'hFF24
`define IDX_EN_CLOCK_LCD 16'hFF25
`define IDX_IRQ_STATUS 16'hFF28
`define IDX_IRQ_CLEAR 16'hFF29
`define IDX_IRQ_ENABLE 16'hFF2A
// ==========================================================
// Writable bit masks
`define MASK_PRIO_ADC_TOUCH 8'hF0
`define MASK_EN_PORT 8'hF8
`define MASK_EN_CLOCK_LCD 8'hFC
`define MASK_EVT 8'h03
// ==========================================================
// Enable bit positions
`define BIT_LOWPORT_EN 3
`define BIT_HIGHPORT0_EN 4
`define BIT_T0_UFLOW_EN 3
`define BIT_T0_MATCH_EN 4
`define BIT_T1_UFLOW_EN 5
`define BIT_T1_MATCH_EN 6
`define BIT_T8_UFLOW_EN 7
`define BIT_SER_RXFAULT_EN 0
`define BIT_SER_RXDONE_EN 1
`define BIT_SER_TXDONE_EN 2
`define BIT_LCD_EN 2
`define BIT_HZ32_EN 3
`define BIT_HZ8_EN 4
`define BIT_HZ2_EN 5
`define BIT_HZ1_EN 6
`define BIT_MIN_EN 7
// ==========================================================
// Reset values
`define RST_REG 8'h00
`endif

// file: core/irq_prio_regs.v
`include "irq_prio_consts.vh"
module irq_prio_regs (
    input wire clk,
    input wire sys_rst,
    input wire [15:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire [7:0] src_lowport,
    input wire [3:0] src_highport,
    input wire src_t0_uflow,
    input wire src_t0_match,
    input wire src_t1_uflow,
    input wire src_t1_match,
    input wire src_t8_uflow,
    input wire src_ser_txdone,
    input wire src_ser_rxdone,
    input wire src_ser_rxfault,
    input wire src_min,
    input wire src_hz1,
    input wire src_hz2,
    input wire src_hz8,
    input wire src_hz32,
    input wire src_lcd,
    input wire src_adc,
    input wire src_touch,
    output reg [17:0] req_vec_ff,
    output reg [1:0] req_level_ff,
    output reg req_any_ff,
    output reg irq_ff
);

// ==========================================================
// Input synchronisers
reg [27:0] sync1_ff;
reg [27:0] sync2_ff;
wire [27:0] raw_src;
assign raw_src = {src_lowport, src_highport, src_t0_uflow, src_t0_match, src_t1_uflow,
    src_t1_match, src_t8_uflow, src_ser_txdone, src_ser_rxdone, src_ser_rxfault, src_min,
    src_hz1, src_hz2, src_hz8, src_hz32, src_lcd, src_adc, src_touch};
always @(posedge clk) begin
    if (sys_rst) begin
        sync1_ff <= 28'h0000000;
        sync2_ff <= 28'h0000000;
    end else begin
        sync1_ff <= raw_src;
        sync2_ff <= sync1_ff;
    end
end

// ==========================================================
// Synchronised source lines
wire [7:0] s_lowport;
wire [3:0] s_high;
wire s_t0_uflow;
wire s_t0_match;
wire s_t1_uflow;
wire s_t1_match;
wire s_t8_uflow;
wire s_txdone;
wire s_rxdone;
wire s_rxfault;
wire s_min;
wire s_hz1;
wire s_hz2;
wire s_hz8;
wire s_hz32;
wire s_lcd;
wire s_adc;
wire s_touch;
assign s_lowport = sync2_ff[27:20];
assign s_high = sync2_ff[19:16];
assign s_t0_uflow = sync2_ff[15];
assign s_t0_match = sync2_ff[14];
assign s_t1_uflow = sync2_ff[13];
assign s_t1_match = sync2_ff[12];
assign s_t8_uflow = sync2_ff[11];
assign s_txdone = sync2_ff[10];
assign s_rxdone = sync2_ff[9];
assign s_rxfault = sync2_ff[8];
assign s_min = sync2_ff[7];
assign s_hz1 = sync2_ff[6];
assign s_hz2 = sync2_ff[5];
assign s_hz8 = sync2_ff[4];
assign s_hz32 = sync2_ff[3];
assign s_lcd = sync2_ff[2];
assign s_adc = sync2_ff[1];
assign s_touch = sync2_ff[0];

// ==========================================================
// Registers
reg [7:0] prio_port_t16_ff;
reg [7:0] prio_misc_ff;
reg [7:0] prio_adc_touch_ff;
reg [7:0] en_port_ff;
reg [7:0] en_timer_serial_ff;
reg [7:0] en_clock_lcd_ff;
reg [1:0] evt_status_ff;
reg [1:0] evt_enable_ff;
reg [1:0] any_prev_ff;

function [31:0] rd_mux;
    input [15:0] a;
    input [7:0] r0, r1, r2, r3, r4, r5;
    input [1:0] st, en;
    begin
        case (a)
            `IDX_PRIO_PORT_T16: rd_mux = {24'h000000, r0};
            `IDX_PRIO_T8_SER_CLK_LCD: rd_mux = {24'h000000, r1};
            `IDX_PRIO_ADC_TOUCH: rd_mux = {24'h000000, r2};
            `IDX_EN_PORT: rd_mux = {24'h000000, r3};
            `IDX_EN_TIMER_SERIAL: rd_mux = {24'h000000, r4};
            `IDX_EN_CLOCK_LCD: rd_mux = {24'h000000, r5};
            `IDX_IRQ_STATUS: rd_mux = {30'h00000000, st};
            `IDX_IRQ_ENABLE: rd_mux = {30'h00000000, en};
            default: rd_mux = 32'h00000000;
        endcase
    end
endfunction

// ==========================================================
// Request gating
wire [17:0] gated;

// ==========================================================
// Port requests
assign gated[17] = (|s_lowport) & en_port_ff[`BIT_LOWPORT_EN];
assign gated[16:13] = s_high & en_port_ff[7:`BIT_HIGHPORT0_EN];

// ==========================================================
// Timer requests
assign gated[12] = s_t0_uflow & en_timer_serial_ff[`BIT_T0_UFLOW_EN];
assign gated[11] = s_t0_match & en_timer_serial_ff[`BIT_T0_MATCH_EN];
assign gated[10] = s_t1_uflow & en_timer_serial_ff[`BIT_T1_UFLOW_EN];
assign gated[9] = s_t1_match & en_timer_serial_ff[`BIT_T1_MATCH_EN];
assign gated[8] = s_t8_uflow & en_timer_serial_ff[`BIT_T8_UFLOW_EN];

// ==========================================================
// Serial requests
assign gated[7] = s_txdone & en_timer_serial_ff[`BIT_SER_TXDONE_EN];
assign gated[6] = s_rxdone & en_timer_serial_ff[`BIT_SER_RXDONE_EN];
assign gated[5] = s_rxfault & en_timer_serial_ff[`BIT_SER_RXFAULT_EN];

// ==========================================================
// Clock timer and display requests
assign gated[4] = s_min & en_clock_lcd_ff[`BIT_MIN_EN];
assign gated[3] = s_hz1 & en_clock_lcd_ff[`BIT_HZ1_EN];
assign gated[2] = s_hz2 & en_clock_lcd_ff[`BIT_HZ2_EN];
assign gated[1] = (s_hz8 & en_clock_lcd_ff[`BIT_HZ8_EN])
    | (s_hz32 & en_clock_lcd_ff[`BIT_HZ32_EN]);
assign gated[0] = s_lcd & en_clock_lcd_ff[`BIT_LCD_EN];

// ==========================================================
// Level tags per group
// Analog groups have no enable in this bank; their priority tags them only
wire [1:0] lvl_lowport = prio_port_t16_ff[5:4];
wire [1:0] lvl_high = prio_port_t16_ff[7:6];
wire [1:0] lvl_t1 = prio_port_t16_ff[3:2];
wire [1:0] lvl_t0 = prio_port_t16_ff[1:0];
wire [1:0] lvl_t8 = prio_misc_ff[7:6];
wire [1:0] lvl_ser = prio_misc_ff[5:4];
wire [1:0] lvl_clk = prio_misc_ff[3:2];
wire [1:0] lvl_lcd = prio_misc_ff[1:0];
wire [1:0] lvl_adc = prio_adc_touch_ff[7:6];
wire [1:0] lvl_touch = prio_adc_touch_ff[5:4];

function [1:0] max2;
    input [1:0] a;
    input [1:0] b;
    begin
        max2 = (a > b) ? a : b;
    end
endfunction

// Level of a group while it requests, else level 0
function [1:0] grp_level;
    input active;
    input [1:0] lvl;
    begin
        grp_level = active ? lvl : 2'h0;
    end
endfunction

wire [1:0] tag_lowport = grp_level(gated[17], lvl_lowport);
wire [1:0] tag_high = grp_level(|gated[16:13], lvl_high);
wire [1:0] tag_t0 = grp_level(gated[12] | gated[11], lvl_t0);
wire [1:0] tag_t1 = grp_level(gated[10] | gated[9], lvl_t1);
wire [1:0] tag_t8 = grp_level(gated[8], lvl_t8);
wire [1:0] tag_ser = grp_level(|gated[7:5], lvl_ser);
wire [1:0] tag_clk = grp_level(|gated[4:1], lvl_clk);
wire [1:0] tag_lcd = grp_level(gated[0], lvl_lcd);
wire [1:0] tag_adc = grp_level(s_adc, lvl_adc);
wire [1:0] tag_touch = grp_level(s_touch, lvl_touch);

reg [1:0] nxt_level;
always @* begin
    nxt_level = 2'h0;
    nxt_level = max2(nxt_level, tag_lowport);
    nxt_level = max2(nxt_level, tag_high);
    nxt_level = max2(nxt_level, tag_t0);
    nxt_level = max2(nxt_level, tag_t1);
    nxt_level = max2(nxt_level, tag_t8);
    nxt_level = max2(nxt_level, tag_ser);
    nxt_level = max2(nxt_level, tag_clk);
    nxt_level = max2(nxt_level, tag_lcd);
    nxt_level = max2(nxt_level, tag_adc);
    nxt_level = max2(nxt_level, tag_touch);
end

// ==========================================================
// Bus slave and register writes
wire wr_hit = avs_write & avs_waitrequest;
wire rd_hit = avs_read & avs_waitrequest;
wire [7:0] wd = avs_writedata[7:0];
wire [17:0] vec_full = gated;
wire any_req = (|gated) | s_touch | s_adc;
wire clk_req = |gated[4:1];
wire [1:0] evt_now;
assign evt_now[0] = any_req & ~any_prev_ff[0];
assign evt_now[1] = clk_req & ~any_prev_ff[1];

function reg_hit;
    input [15:0] a;
    input [15:0] idx;
    begin
        reg_hit = (a == idx);
    end
endfunction

wire wr_prio_port_t16 = wr_hit & reg_hit(avs_address, `IDX_PRIO_PORT_T16);
wire wr_prio_misc = wr_hit & reg_hit(avs_address, `IDX_PRIO_T8_SER_CLK_LCD);
wire wr_prio_adc_touch = wr_hit & reg_hit(avs_address, `IDX_PRIO_ADC_TOUCH);
wire wr_en_port = wr_hit & reg_hit(avs_address, `IDX_EN_PORT);
wire wr_en_timer_serial = wr_hit & reg_hit(avs_address, `IDX_EN_TIMER_SERIAL);
wire wr_en_clock_lcd = wr_hit & reg_hit(avs_address, `IDX_EN_CLOCK_LCD);
wire wr_evt_clear = wr_hit & reg_hit(avs_address, `IDX_IRQ_CLEAR);
wire wr_evt_enable = wr_hit & reg_hit(avs_address, `IDX_IRQ_ENABLE);

// ==========================================================
// Bus handshake: one wait cycle, then one answer cycle
always @(posedge clk) begin
    if (sys_rst) begin
        avs_waitrequest <= 1'b1;
    end else begin
        avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
end

// ==========================================================
// Read data
always @(posedge clk) begin
    if (sys_rst) begin
        avs_readdata <= 32'h00000000;
    end else if (rd_hit) begin
        avs_readdata <= rd_mux(avs_address, prio_port_t16_ff, prio_misc_ff,
            prio_adc_touch_ff, en_port_ff, en_timer_serial_ff, en_clock_lcd_ff,
            evt_status_ff, evt_enable_ff);
    end
end

// ==========================================================
// Priority registers
// Port and 16-bit timer levels
always @(posedge clk) begin
    if (sys_rst) begin
        prio_port_t16_ff <= `RST_REG;
    end else if (wr_prio_port_t16) begin
        prio_port_t16_ff <= wd;
    end
end

// 8-bit timer, serial, clock timer and display levels
always @(posedge clk) begin
    if (sys_rst) begin
        prio_misc_ff <= `RST_REG;
    end else if (wr_prio_misc) begin
        prio_misc_ff <= wd;
    end
end

// Converter and touch levels; low nibble unimplemented
always @(posedge clk) begin
    if (sys_rst) begin
        prio_adc_touch_ff <= `RST_REG;
    end else if (wr_prio_adc_touch) begin
        prio_adc_touch_ff <= wd & `MASK_PRIO_ADC_TOUCH;
    end
end

// ==========================================================
// Enable registers
// Port enables; low three bits unimplemented
always @(posedge clk) begin
    if (sys_rst) begin
        en_port_ff <= `RST_REG;
    end else if (wr_en_port) begin
        en_port_ff <= wd & `MASK_EN_PORT;
    end
end

// Timer and serial enables
always @(posedge clk) begin
    if (sys_rst) begin
        en_timer_serial_ff <= `RST_REG;
    end else if (wr_en_timer_serial) begin
        en_timer_serial_ff <= wd;
    end
end

// Clock timer and display enables; low two bits unimplemented
always @(posedge clk) begin
    if (sys_rst) begin
        en_clock_lcd_ff <= `RST_REG;
    end else if (wr_en_clock_lcd) begin
        en_clock_lcd_ff <= wd & `MASK_EN_CLOCK_LCD;
    end
end

// ==========================================================
// Event status, enable and clear
always @(posedge clk) begin
    if (sys_rst) begin
        evt_enable_ff <= 2'h0;
    end else if (wr_evt_enable) begin
        evt_enable_ff <= wd[1:0];
    end
end

// Set wins over clear
always @(posedge clk) begin
    if (sys_rst) begin
        evt_status_ff <= 2'h0;
    end else if (wr_evt_clear) begin
        evt_status_ff <= (evt_status_ff & ~wd[1:0]) | evt_now;
    end else begin
        evt_status_ff <= evt_status_ff | evt_now;
    end
end

// Previous request levels for rise detection
always @(posedge clk) begin
    if (sys_rst) begin
        any_prev_ff <= 2'h0;
    end else begin
        any_prev_ff <= {clk_req, any_req};
    end
end

// ==========================================================
// Outputs
always @(posedge clk) begin
    if (sys_rst) begin
        req_vec_ff <= 18'h00000;
        req_level_ff <= 2'h0;
        req_any_ff <= 1'b0;
        irq_ff <= 1'b0;
    end else begin
        req_vec_ff <= vec_full;
        req_level_ff <= nxt_level;
        req_any_ff <= any_req;
        irq_ff <= |(evt_status_ff & evt_enable_ff);
    end
end

endmodule

// file: tb/irq_src_model.sv
module irq_src_model (
    input wire clk,
    input wire [4:0] sel,
    input wire on,
    output logic [27:0] src_lines
);
    timeunit 1ns;
    timeprecision 1ns;
    // One event source high at a time
    initial src_lines = 28'h0;
    always @(posedge clk) begin
        src_lines <= on ? 28'h1 << sel : 28'h0;
    end
endmodule

// file: tb/irq_prio_regs_asserts.sv
module irq_prio_regs_chk (
    input wire clk,
    input wire sys_rst,
    input wire [15:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire src_lcd,
    input wire src_ser_txdone,
    input wire [17:0] req_vec_ff,
    input wire [1:0] req_level_ff,
    input wire req_any_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire rd_done = avs_read && !avs_waitrequest;
    sequence taken_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence answer_s;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    bus_answer_a: assert property (taken_s |=> answer_s) else $error("bad answer");
    idle_wait_a: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
        else $error("idle");
    reset_clear_a: assert property ($fell(sys_rst) |-> req_vec_ff == 18'h0 && !req_any_ff)
        else $error("reset value");
    upper_zero_a: assert property (rd_done |-> avs_readdata[31:8] == 24'h0)
        else $error("upper bits");
    adc_mask_a: assert property (rd_done && avs_address == 16'hFF22
        |-> avs_readdata[3:0] == 4'h0) else $error("mask bits");
    lcd_gate_a: assert property (req_vec_ff[0] |-> $past(src_lcd, 3))
        else $error("display gate");
    tx_gate_a: assert property (req_vec_ff[7] |-> $past(src_ser_txdone, 3))
        else $error("tx gate");
    level_any_a: assert property (req_level_ff != 2'h0 |-> req_any_ff)
        else $error("level");
endmodule
bind irq_prio_regs irq_prio_regs_chk u_chk (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .src_lcd(src_lcd),
    .src_ser_txdone(src_ser_txdone), .req_vec_ff(req_vec_ff), .req_level_ff(req_level_ff),
    .req_any_ff(req_any_ff));

// file: tb/irq_prio_regs_tb.sv
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module irq_prio_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, on = 0, avs_waitrequest, irq_ff;
    logic [15:0] avs_address = 16'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [17:0] req_vec_ff;
    logic [1:0] req_level_ff;
    logic [4:0] sel = 5'h0;
    logic [27:0] s;
    logic [7:0] d;
    logic req_any_ff;
    int n_mismatch = 0, samples_checked = 0, cyc = 0, e, k, r;
    int tbl[17] = '{1733, 111637, 81334, 121243, 131144, 141045, 150946, 160847, 170742,
        180641, 190540, 200457, 210356, 220255, 230154, 240153, 250052};
    initial forever #20 clk = ~clk;
    irq_src_model part (.clk(clk), .sel(sel), .on(on), .src_lines(s));
    irq_prio_regs dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .src_lowport(s[7:0]),
        .src_highport(s[11:8]), .src_t0_uflow(s[12]), .src_t0_match(s[13]),
        .src_t1_uflow(s[14]), .src_t1_match(s[15]), .src_t8_uflow(s[16]),
        .src_ser_txdone(s[17]), .src_ser_rxdone(s[18]), .src_ser_rxfault(s[19]),
        .src_min(s[20]), .src_hz1(s[21]), .src_hz2(s[22]), .src_hz8(s[23]), .src_hz32(s[24]),
        .src_lcd(s[25]), .src_adc(s[26]), .src_touch(s[27]), .req_vec_ff(req_vec_ff),
        .req_level_ff(req_level_ff), .req_any_ff(req_any_ff), .irq_ff(irq_ff));
    // ==========================================================
    // Expected read-back of a written byte
    function automatic [7:0] exp_rd(int n, int v);
        case (n)
            2: exp_rd = 8'(v) & 8'hF0;
            3: exp_rd = 8'(v) & 8'hF8;
            5: exp_rd = 8'(v) & 8'hFC;
            6, 7: exp_rd = 8'h00;
            default: exp_rd = 8'(v);
        endcase
    endfunction
    task automatic bus(input bit w, input int a, input int v);
        @(posedge clk);
        avs_address <= 16'hFF00 | 16'(a);
        avs_writedata <= 32'(v);
        avs_read <= !w;
        avs_write <= w;
        @(posedge clk);
        while (avs_waitrequest !== 1'h0) @(posedge clk);
        d = avs_readdata[7:0];
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_mismatch++;
            final_report;
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        k = $urandom(43788);
        repeat (20) @(posedge clk);
        sys_rst <= 1'h0;
        for (int i = 0; i < 11; i++) begin
            bus(0, 'h20 + i, 0);
            `CHK(d, 8'h00)
        end
        for (int i = 0; i < 24; i++) begin
            k = (i < 8) ? i : $urandom % 8;
            e = $urandom % 256;
            bus(1, 'h20 + k, e);
            bus(0, 'h20 + k, 0);
            `CHK(d, exp_rd(k, e))
        end
        foreach (tbl[i]) begin
            r = (tbl[i] / 10) % 10;
            for (int g = 3; g < 6; g++) bus(1, 'h20 + g, (g == r) ? 1 << (tbl[i] % 10) : 0);
            sel <= 5'(tbl[i] / 10000 + ((tbl[i] < 10000) ? $urandom % 8 : 0));
            on <= 1'h1;
            repeat (5) @(posedge clk);
            `CHK(req_vec_ff, 18'h1 << ((tbl[i] / 100) % 100))
            `CHK(req_any_ff, 1'h1)
            bus(1, 'h20 + r, 0);
            repeat (5) @(posedge clk);
            `CHK(req_vec_ff, 18'h0)
            `CHK(req_any_ff, 1'h0)
            on <= 1'h0;
        end
        bus(1, 'h2A, 0);
        bus(1, 'h25, 'h40);
        sel <= 5'h15;
        on <= 1'h1;
        repeat (5) @(posedge clk);
        bus(0, 'h28, 0);
        `CHK(d, 8'h03)
        `CHK(irq_ff, 1'h0)
        bus(1, 'h2A, 'h02);
        repeat (3) @(posedge clk);
        `CHK(irq_ff, 1'h1)
        bus(1, 'h29, 'h03);
        repeat (3) @(posedge clk);
        `CHK(irq_ff, 1'h0)
        bus(1, 'h25, 'h04);
        sel <= 5'h19;
        for (int lv = 0; lv < 4; lv++) begin
            bus(1, 'h21, lv | (($urandom % 64) << 2));
            repeat (5) @(posedge clk);
            `CHK(req_level_ff, 2'(lv))
        end
        bus(1, 'h22, 'hB0);
        sel <= 5'h1B;
        repeat (5) @(posedge clk);
        `CHK(req_level_ff, 2'h3)
        `CHK(req_vec_ff, 18'h0)
        sel <= 5'h1A;
        repeat (5) @(posedge clk);
        `CHK(req_level_ff, 2'h2)
        `CHK(req_any_ff, 1'h1)
        final_report;
    end
endmodule
